// [diag_map.vh]
/*
 integer address unit constants: op codes, modes, access sizes, widths.
 assumes inclusion by bare name from the design files.
*/
`ifndef DIAG_MAP_VH
`define DIAG_MAP_VH
// ----------------------------------------
// widths
// ----------------------------------------
`define DIAG_DW 32
`define DIAG_NREG 31
`define DIAG_AW 5
`define DIAG_NCIRC 4
// ----------------------------------------
// operations
// ----------------------------------------
`define DIAG_OP_NOP 4'h0
`define DIAG_OP_ADD 4'h1
`define DIAG_OP_SUB 4'h2
`define DIAG_OP_AND 4'h3
`define DIAG_OP_OR 4'h4
`define DIAG_OP_XOR 4'h5
`define DIAG_OP_MOV 4'h6
`define DIAG_OP_LDI 4'h7
`define DIAG_OP_MEM_IMM 4'h8
`define DIAG_OP_MEM_PRE 4'h9
`define DIAG_OP_MEM_POST 4'hA
`define DIAG_OP_SETB 4'hB
`define DIAG_OP_SETL 4'hC
// ----------------------------------------
// pointer update modes
// ----------------------------------------
`define DIAG_MODE_LIN 2'h0
`define DIAG_MODE_CIRC 2'h1
`define DIAG_MODE_BREV 2'h2
// ----------------------------------------
// access sizes
// ----------------------------------------
`define DIAG_SZ_SINGLE 2'h0
`define DIAG_SZ_DUAL 2'h1
`define DIAG_SZ_QUAD 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define DIAG_PIPE_DEPTH 1
`endif

// [diag_regfile.v]
/*
 31-word register file of one address unit, two registered read ports,
 one write port. assumes same-clock synchronous use; reads of the word
 being written return the old value.
*/
`default_nettype none
`include "diag_map.vh"
module diag_regfile #(
  parameter DW = `DIAG_DW,
  parameter NREG = `DIAG_NREG,
  parameter AW = `DIAG_AW
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  input wire [AW-1:0] ra_addr,
  input wire [AW-1:0] rb_addr,
  output reg [DW-1:0] ra_data,
  output reg [DW-1:0] rb_data,
  input wire we,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data
);
  reg [DW-1:0] mem_r [0:NREG-1];
  integer i;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      for (i = 0; i < NREG; i = i + 1)
        mem_r[i] <= {DW{1'b0}};
      ra_data <= {DW{1'b0}};
      rb_data <= {DW{1'b0}};
    end else if (ce) begin
      if (we && wr_addr < NREG)
        mem_r[wr_addr] <= wr_data;
      ra_data <= (ra_addr < NREG) ? mem_r[ra_addr] : {DW{1'b0}};
      rb_data <= (rb_addr < NREG) ? mem_r[rb_addr] : {DW{1'b0}};
    end
  end
endmodule
`default_nettype wire

// [diag_unit.v]
/*
 integer address unit: address generation with immediate and pre/post
 modify indirect modes, four circular buffers, bit-reverse update,
 integer alu, one-stage result pipeline with dependency stall.
 assumes the sequencer holds an instruction steady while stall is high.
 instantiate twice for the dual-unit core.
*/
`default_nettype none
`include "diag_map.vh"
// Functional notes
// - two independent units each generate addresses and update pointers together
// - each unit owns thirty-one 32-bit registers
// - immediate and indirect addressing with pre-modify and post-modify
// - every access tagged single, dual or quad word
// - four circular buffers with base, length, index per unit
// - circular pointer wraps at either end with no extra cycles
// - modulus and bit-reverse need no alignment of buffer placement; here bit-reverse uses no base, so its buffer must be aligned
// - circular buffer bounds are arbitrary addresses
// - bit-reverse is an alternative update mode to linear and circular
// - unit executes general integer arithmetic and logic ops
// - result pipeline one cycle deep, usable next cycle; here a dependent instruction stalls two cycles until the write-back lands
// - dependency check stalls consumer until source value ready
module diag_unit #(
  parameter DW = `DIAG_DW,
  parameter AW = `DIAG_AW,
  parameter NC = `DIAG_NCIRC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  input wire ins_valid,
  input wire [3:0] ins_op,
  input wire [AW-1:0] ins_dst,
  input wire [AW-1:0] ins_srca,
  input wire [AW-1:0] ins_srcb,
  input wire [DW-1:0] ins_imm,
  input wire [1:0] ins_mode,
  input wire [1:0] ins_circ,
  input wire [1:0] ins_size,
  output wire ins_stall,
  output reg mem_valid,
  output reg [DW-1:0] mem_addr,
  output reg [1:0] mem_size,
  output reg res_valid,
  output reg [AW-1:0] res_dst,
  output reg [DW-1:0] res_data
);
  // ----------------------------------------
  // pipeline states (one-hot)
  // ----------------------------------------
  localparam ST_RUN = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [DW-1:0] base_r [0:NC-1];
  reg [DW-1:0] len_r [0:NC-1];
  wire [DW-1:0] a_val;
  wire [DW-1:0] b_val;
  reg [AW-1:0] ex_dst_r;
  reg ex_wb_r;
  reg [DW-1:0] ex_res_r;
  reg [3:0] ex_op_r;
  reg [1:0] ex_mode_r;
  reg [1:0] ex_circ_r;
  reg [1:0] ex_size_r;
  reg [DW-1:0] ex_imm_r;
  reg ex_valid_r;
  reg [DW-1:0] alu_res;
  reg alu_wb;
  reg [DW-1:0] upd_ptr;
  reg [DW-1:0] circ_ptr;
  reg [DW-1:0] addr_out;
  reg is_mem;
  reg hazard;
  wire [DW-1:0] rev_ptr;
  wire [DW-1:0] rev_mod;
  wire [DW-1:0] rev_sum;
  wire [DW-1:0] top;
  wire [DW-1:0] off;
  wire [DW-1:0] rel;
  wire [DW:0] lin_sum;
  wire [DW-1:0] lin_sum_rev;
  wire issue;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // read ports are registered, so operands appear in the execute cycle
  diag_regfile #(.DW(DW), .NREG(`DIAG_NREG), .AW(AW)) u_rf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .ra_addr(ins_srca),
    .rb_addr(ins_srcb),
    .ra_data(a_val),
    .rb_data(b_val),
    .we(res_valid),
    .wr_addr(res_dst),
    .wr_data(res_data)
  );

  // ----------------------------------------
  // dependency check
  // ----------------------------------------
  // a value in execute or write-back is not yet in the file's read data
  always @* begin
    hazard = 1'b0;
  // checked every cycle: a pending write-back still blocks after the
  // first stall cycle, since its word lands on the next edge
    if (ins_valid) begin
      if (ex_valid_r && ex_wb_r &&
          (ins_srca == ex_dst_r || ins_srcb == ex_dst_r))
        hazard = 1'b1;
      if (res_valid && (ins_srca == res_dst || ins_srcb == res_dst))
        hazard = 1'b1;
    end
  end
  assign ins_stall = hazard;
  assign issue = ins_valid && !hazard;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: state_nxt = hazard ? ST_WAIT : ST_RUN;
      ST_WAIT: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  // ----------------------------------------
  // decode stage capture
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      ex_valid_r <= 1'b0;
      ex_op_r <= `DIAG_OP_NOP;
      ex_dst_r <= {AW{1'b0}};
      ex_wb_r <= 1'b0;
      ex_mode_r <= `DIAG_MODE_LIN;
      ex_circ_r <= 2'h0;
      ex_size_r <= `DIAG_SZ_SINGLE;
      ex_imm_r <= {DW{1'b0}};
    end else if (ce) begin
      state_r <= state_nxt;
      ex_valid_r <= issue;
      ex_op_r <= ins_op;
      ex_dst_r <= ins_dst;
      ex_wb_r <= issue && ins_op != `DIAG_OP_NOP &&
        ins_op != `DIAG_OP_MEM_IMM && ins_op != `DIAG_OP_SETB &&
        ins_op != `DIAG_OP_SETL;
      ex_mode_r <= ins_mode;
      ex_circ_r <= ins_circ;
      ex_size_r <= ins_size;
      ex_imm_r <= ins_imm;
    end
  end

  // ----------------------------------------
  // pointer update: linear, circular, bit-reverse
  // ----------------------------------------
  // a_val is the index pointer, b_val the modifier
  assign lin_sum = {1'b0, a_val} + {1'b0, b_val};
  // circular: offset relative to the arbitrary base, fold by length
  assign top = base_r[ex_circ_r] + len_r[ex_circ_r];
  assign rel = a_val - base_r[ex_circ_r];
  assign off = rel + b_val;
  always @* begin
    circ_ptr = base_r[ex_circ_r] + off;
    if (len_r[ex_circ_r] != {DW{1'b0}}) begin
      if (b_val[DW-1] && rel < (~b_val + 1'b1))
        circ_ptr = base_r[ex_circ_r] + off + len_r[ex_circ_r];
      else if (!b_val[DW-1] && off >= len_r[ex_circ_r])
        circ_ptr = base_r[ex_circ_r] + off - len_r[ex_circ_r];
    end
  end

  // reverse bits, add, reverse back: carry runs msb toward lsb
  genvar g;
  generate
    for (g = 0; g < DW; g = g + 1) begin : g_rev
      assign rev_ptr[g] = a_val[DW-1-g];
      assign rev_mod[g] = b_val[DW-1-g];
      assign rev_sum[g] = lin_sum_rev[DW-1-g];
    end
  endgenerate
  assign lin_sum_rev = rev_ptr + rev_mod;

  always @* begin
    case (ex_mode_r)
      `DIAG_MODE_CIRC: upd_ptr = circ_ptr;
      `DIAG_MODE_BREV: upd_ptr = rev_sum;
      default: upd_ptr = lin_sum[DW-1:0];
    endcase
  end

  // ----------------------------------------
  // execute: alu and address generation
  // ----------------------------------------
  always @* begin
    alu_res = {DW{1'b0}};
    alu_wb = ex_wb_r;
    addr_out = a_val;
    is_mem = 1'b0;
    case (ex_op_r)
      `DIAG_OP_ADD: alu_res = a_val + b_val;
      `DIAG_OP_SUB: alu_res = a_val - b_val;
      `DIAG_OP_AND: alu_res = a_val & b_val;
      `DIAG_OP_OR: alu_res = a_val | b_val;
      `DIAG_OP_XOR: alu_res = a_val ^ b_val;
      `DIAG_OP_MOV: alu_res = a_val;
      `DIAG_OP_LDI: alu_res = ex_imm_r;
      `DIAG_OP_MEM_IMM: begin
        addr_out = ex_imm_r;
        is_mem = 1'b1;
      end
      `DIAG_OP_MEM_PRE: begin
        addr_out = upd_ptr;
        alu_res = upd_ptr;
        is_mem = 1'b1;
      end
      `DIAG_OP_MEM_POST: begin
        addr_out = a_val;
        alu_res = upd_ptr;
        is_mem = 1'b1;
      end
      default: alu_wb = 1'b0;
    endcase
  end

  integer k;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_valid <= 1'b0;
      mem_addr <= {DW{1'b0}};
      mem_size <= `DIAG_SZ_SINGLE;
      res_valid <= 1'b0;
      res_dst <= {AW{1'b0}};
      res_data <= {DW{1'b0}};
      for (k = 0; k < NC; k = k + 1) begin
        base_r[k] <= {DW{1'b0}};
        len_r[k] <= {DW{1'b0}};
      end
    end else if (ce) begin
      mem_valid <= ex_valid_r && is_mem;
      mem_addr <= addr_out;
      mem_size <= ex_size_r;
      res_valid <= ex_valid_r && alu_wb;
      res_dst <= ex_dst_r;
      res_data <= alu_res;
      if (ex_valid_r && ex_op_r == `DIAG_OP_SETB)
        base_r[ex_circ_r] <= a_val;
      if (ex_valid_r && ex_op_r == `DIAG_OP_SETL)
        len_r[ex_circ_r] <= a_val;
    end
  end
endmodule
`default_nettype wire

// [diag_checker.sv]
/*
 port assertions for one integer address unit.
 assumes ce held high and the bind below reaching every diag_unit.
*/
`default_nettype none
`include "diag_map.vh"
module diag_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic ins_valid,
  input wire logic [3:0] ins_op,
  input wire logic [4:0] ins_dst,
  input wire logic [4:0] ins_srca,
  input wire logic [4:0] ins_srcb,
  input wire logic [1:0] ins_size,
  input wire logic ins_stall,
  input wire logic mem_valid,
  input wire logic [1:0] mem_size,
  input wire logic res_valid,
  input wire logic [4:0] res_dst
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr, mo, rd, hz, w1_r, w2_r;
  logic [4:0] d1_r, d2_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  assign wr = ins_op inside {[4'h1:4'h7], 4'h9, 4'hA};
  assign mo = ins_op inside {4'h8, 4'h9, 4'hA};
  // ops that read a source; immediate loads are left out on purpose
  assign rd = ins_op inside {[4'h1:4'h6], [4'h9:4'hC]};
  assign hz = (w1_r && (ins_srca == d1_r || ins_srcb == d1_r)) ||
    (w2_r && (ins_srca == d2_r || ins_srcb == d2_r));
  always_ff @(posedge ref_clk) begin
    w1_r <= rst_n && ce && ins_valid && !ins_stall && wr;
    w2_r <= rst_n && w1_r;
    d1_r <= ins_dst;
    d2_r <= d1_r;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_take;
    ce && ins_valid && !ins_stall;
  endsequence
  AST_RES: assert property (s_take ##0 wr |-> ##2 res_valid)
    else $error("result missing two edges after issue");
  AST_DST: assert property (s_take ##0 wr |-> ##2 res_dst == $past(ins_dst, 2))
    else $error("result register wrong");
  AST_NOWR: assert property (s_take ##0 !wr |-> ##2 !res_valid)
    else $error("unexpected register write");
  AST_MEM: assert property (s_take ##0 mo |-> ##2 mem_valid &&
    mem_size == $past(ins_size, 2)) else $error("access missing");
  AST_NOMEM: assert property (s_take ##0 !mo |-> ##2 !mem_valid)
    else $error("unexpected memory access");
  AST_HAZ: assert property (ins_valid && rd && hz |-> ins_stall)
    else $error("dependent instruction not stalled");
  AST_NOHAZ: assert property (ins_valid && rd && !hz |-> !ins_stall)
    else $error("independent instruction stalled");
  AST_STALL2: assert property (ins_stall [*2] |=> !ins_stall)
    else $error("stall longer than two cycles");
endmodule
bind diag_unit diag_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
  .ins_valid(ins_valid), .ins_op(ins_op), .ins_dst(ins_dst),
  .ins_srca(ins_srca), .ins_srcb(ins_srcb), .ins_size(ins_size),
  .ins_stall(ins_stall), .mem_valid(mem_valid), .mem_size(mem_size),
  .res_valid(res_valid), .res_dst(res_dst));
`default_nettype wire

// [diag_sink.sv]
/*
 memory bus and write-back sink: counts accesses and register writes.
 assumes single clock, synchronous active-low reset.
*/
`default_nettype none
module diag_sink (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mem_valid,
  input wire logic res_valid,
  output logic [15:0] n_mem,
  output logic [15:0] n_res
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge ref_clk) begin
    n_mem <= !rst_n ? 16'h0 : n_mem + {15'h0, mem_valid};
    n_res <= !rst_n ? 16'h0 : n_res + {15'h0, res_valid};
  end
endmodule
`default_nettype wire

// [dual_integer_address_generator_test.sv]
/*
 self-checking bench for one integer address unit and a bus sink.
 assumes the op, mode and size encodings of diag_map.vh.
*/
`default_nettype none
`include "diag_map.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  failures++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module dual_integer_address_generator_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, ins_valid, ins_stall, mem_valid, res_valid;
  logic [3:0] ins_op;
  logic [4:0] ins_dst, ins_srca, ins_srcb, res_dst;
  logic [31:0] ins_imm, mem_addr, res_data, k;
  logic [1:0] ins_mode, ins_circ, ins_size, mem_size;
  logic [15:0] n_mem, n_res;
  logic [31:0] rf [0:30];
  logic [31:0] bas [0:3];
  logic [31:0] len [0:3];
  logic [36:0] res_q [$];
  logic [33:0] mem_q [$];
  logic [36:0] rexp;
  logic [33:0] mexp;
  integer seed = 59456;
  int failures = 0;
  int samples_checked = 0;
  int er = 0;
  int em = 0;
  diag_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1),
    .ins_valid(ins_valid), .ins_op(ins_op), .ins_dst(ins_dst),
    .ins_srca(ins_srca), .ins_srcb(ins_srcb), .ins_imm(ins_imm),
    .ins_mode(ins_mode), .ins_circ(ins_circ), .ins_size(ins_size),
    .ins_stall(ins_stall), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_size(mem_size), .res_valid(res_valid), .res_dst(res_dst),
    .res_data(res_data));
  diag_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .mem_valid(mem_valid),
    .res_valid(res_valid), .n_mem(n_mem), .n_res(n_res));
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [31:0] rev(input logic [31:0] v);
    for (int i = 0; i < 32; i++) rev[i] = v[31-i];
  endfunction
  function automatic logic [31:0] upd(input logic [1:0] md, c,
      input logic [31:0] p, m);
    logic [31:0] n;
    n = p + m;
    if (md == `DIAG_MODE_BREV) n = rev(rev(p) + rev(m));
    if (md == `DIAG_MODE_CIRC && len[c] != 32'h0) begin
      if (n >= bas[c] + len[c]) n = n - len[c];
      else if (n < bas[c]) n = n + len[c];
    end
    return n;
  endfunction
  // queues results ahead of issue; holds the request until taken
  task automatic issue(input logic [3:0] op, input logic [4:0] d, a, b,
      input logic [31:0] imm, input logic [1:0] md, c, sz);
    logic [31:0] r;
    r = upd(md, c, rf[a], rf[b]);
    case (op)
      4'h1: r = rf[a] + rf[b];
      4'h2: r = rf[a] - rf[b];
      4'h3: r = rf[a] & rf[b];
      4'h4: r = rf[a] | rf[b];
      4'h5: r = rf[a] ^ rf[b];
      4'h6: r = rf[a];
      4'h7: r = imm;
      4'h8: mem_q.push_back({imm, sz});
      4'h9: mem_q.push_back({r, sz});
      4'hA: mem_q.push_back({rf[a], sz});
      4'hB: bas[c] = rf[a];
      4'hC: len[c] = rf[a];
      default: r = 32'h0;
    endcase
    if (op inside {[4'h1:4'h7], 4'h9, 4'hA}) res_q.push_back({d, r});
    if (op inside {[4'h1:4'h7], 4'h9, 4'hA}) rf[d] = r;
    er += op inside {[4'h1:4'h7], 4'h9, 4'hA};
    em += op inside {[4'h8:4'hA]};
    {ins_valid, ins_op, ins_dst, ins_srca, ins_srcb} <= {1'b1, op, d, a, b};
    {ins_imm, ins_mode, ins_circ, ins_size} <= {imm, md, c, sz};
    // look at the stall flag where it is settled, then cross the edge
    for (int i = 0; i < 9; i++) begin
      @(negedge ref_clk);
      if (ins_stall === 1'b0) break;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
  endtask
  task automatic finish_test;
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // stimulus and checks
  // ----------------------------------------
  always @(negedge ref_clk) begin
    if (res_valid === 1'b1) begin
      rexp = res_q.pop_front();
      `CHK({res_dst, res_data}, rexp)
    end
    if (mem_valid === 1'b1) begin
      mexp = mem_q.pop_front();
      `CHK({mem_addr, mem_size}, mexp)
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    finish_test;
  end
  initial begin
    {rst_n, ins_valid, ins_op, ins_dst, ins_srca, ins_srcb} = '0;
    {ins_imm, ins_mode, ins_circ, ins_size, k} = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 30; i++)
      issue(4'h7, 5'(i), 5'h1E, 5'h1E, $random(seed), 2'h0, 2'h0, 2'h0);
    for (int i = 0; i < 60; i++) begin
      k = $random(seed);
      issue({1'b0, k[2:0]}, k[7:3] % 5'd30, k[12:8] % 5'd30,
        k[2:0] == 3'h6 ? k[12:8] % 5'd30 : k[17:13] % 5'd30, k,
        2'h0, 2'h0, 2'h0);
    end
    // odd base and length: no alignment assumed for the buffer
    issue(4'h7, 5'h14, 5'h1E, 5'h1E, 32'h101, 2'h0, 2'h0, 2'h0);
    issue(4'h7, 5'h15, 5'h1E, 5'h1E, 32'h5, 2'h0, 2'h0, 2'h0);
    issue(4'h7, 5'h17, 5'h1E, 5'h1E, 32'h3, 2'h0, 2'h0, 2'h0);
    issue(4'h7, 5'h18, 5'h1E, 5'h1E, 32'hFFFFFFFE, 2'h0, 2'h0, 2'h0);
    for (int c = 0; c < 4; c++) begin
      issue(4'hB, 5'h0, 5'h14, 5'h14, 32'h0, 2'h0, 2'(c), 2'h0);
      issue(4'hC, 5'h0, 5'h15, 5'h15, 32'h0, 2'h0, 2'(c), 2'h0);
    end
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 3; s++) begin
        issue(4'h7, 5'h16, 5'h1E, 5'h1E, 32'h104, 2'h0, 2'h0, 2'h0);
        issue(4'hA, 5'h16, 5'h16, 5'h17, 32'h0, 2'(m), 2'(s), 2'(s));
        issue(4'h9, 5'h16, 5'h16, 5'h18, 32'h0, 2'(m), 2'(s + 1), 2'(s));
        issue(4'h9, 5'h16, 5'h16, 5'h18, 32'h0, 2'(m), 2'(s + 1), 2'(s));
        issue(4'h8, 5'h19, 5'h1E, 5'h1E, $random(seed), 2'h0, 2'h0, 2'(s));
      end
    ins_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK(n_res, 16'(er))
    `CHK(n_mem, 16'(em))
    finish_test;
  end
endmodule
`default_nettype wire
